// ---- bsbe_pkg.sv ----
/*
 * Shared constants and types for the branch, skip and bit-operation
 * execution slice: operation codes, flag positions, cycle counts and the
 * small control register map.
 * Assumes a decode stage that has already classified the instruction.
 */
`default_nettype none

package bsbe_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned PC_W   = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned IO_W   = 6;
    localparam int unsigned OFS_W  = 7;
    localparam int unsigned CSR_W  = 2;

    // ************************************************************
    // Status flag positions
    // ************************************************************
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ************************************************************
    // Program counter steps and cycle counts
    // ************************************************************
    localparam logic [PC_W-1:0] PC_STEP_1 = 16'h0001;
    localparam logic [PC_W-1:0] PC_STEP_2 = 16'h0002;
    localparam logic [PC_W-1:0] PC_STEP_3 = 16'h0003;
    localparam logic [1:0]      CYC_1     = 2'h1;
    localparam logic [1:0]      CYC_2     = 2'h2;
    localparam logic [1:0]      CYC_3     = 2'h3;

    // ************************************************************
    // Control registers
    // ************************************************************
    localparam logic [CSR_W-1:0]  CSR_CTRL   = 2'h0;
    localparam logic [CSR_W-1:0]  CSR_STAT   = 2'h1;
    localparam logic [CSR_W-1:0]  CSR_COUNT  = 2'h2;
    localparam logic [DATA_W-1:0] CTRL_RST   = 8'h01;
    localparam int unsigned       CTRL_EN    = 0;
    localparam int unsigned       CTRL_CLR   = 1;
    localparam int unsigned       STAT_BUSY  = 0;
    localparam int unsigned       STAT_TAKEN = 1;

    // ************************************************************
    // Operations
    // ************************************************************
    typedef enum logic [4:0] {
        OP_NONE                      = 5'h00,
        OP_SKIP_REG_BIT_CLEAR        = 5'h01,
        OP_SKIP_REG_BIT_SET          = 5'h02,
        OP_SKIP_IO_BIT_CLEAR         = 5'h03,
        OP_SKIP_IO_BIT_SET           = 5'h04,
        OP_BRANCH_FLAG_SET           = 5'h05,
        OP_BRANCH_FLAG_CLEAR         = 5'h06,
        OP_BRANCH_EQUAL              = 5'h07,
        OP_BRANCH_NOT_EQUAL          = 5'h08,
        OP_BRANCH_CARRY_SET          = 5'h09,
        OP_BRANCH_CARRY_CLEAR        = 5'h0a,
        OP_BRANCH_SAME_OR_HIGHER     = 5'h0b,
        OP_BRANCH_LOWER              = 5'h0c,
        OP_BRANCH_MINUS              = 5'h0d,
        OP_BRANCH_PLUS               = 5'h0e,
        OP_BRANCH_SIGNED_GE          = 5'h0f,
        OP_BRANCH_SIGNED_LESS        = 5'h10,
        OP_BRANCH_HALF_CARRY_SET     = 5'h11,
        OP_BRANCH_HALF_CARRY_CLEAR   = 5'h12,
        OP_BRANCH_TRANSFER_BIT_SET   = 5'h13,
        OP_BRANCH_TRANSFER_BIT_CLEAR = 5'h14,
        OP_BRANCH_OVERFLOW_SET       = 5'h15,
        OP_BRANCH_OVERFLOW_CLEAR     = 5'h16,
        OP_BRANCH_IRQ_ENABLED        = 5'h17,
        OP_BRANCH_IRQ_DISABLED       = 5'h18,
        OP_SET_IO_BIT                = 5'h19,
        OP_CLEAR_IO_BIT              = 5'h1a,
        OP_SHIFT_LEFT_LOGICAL        = 5'h1b,
        OP_SHIFT_RIGHT_LOGICAL       = 5'h1c,
        OP_ROTATE_LEFT_CARRY         = 5'h1d
    } bsbe_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_HOLD = 1'b1
    } bsbe_state_t;

endpackage

`default_nettype wire

// ---- bsbe_shift.sv ----
/*
 * One-bit shift and rotate unit: result byte and updated status flags.
 * Assumes the operand and flags are stable for the cycle it is used in.
 */
`timescale 1ns/1ns
`default_nettype none

module bsbe_shift
    import bsbe_pkg::*;
(
    input  wire logic [4:0]        op,
    input  wire logic [DATA_W-1:0] val,
    input  wire logic [DATA_W-1:0] flags_in,
    output logic      [DATA_W-1:0] res,
    output logic      [DATA_W-1:0] flags_res
);

    // ************************************************************
    // Data path
    // ************************************************************
    logic is_lsl;
    logic is_lsr;
    logic carry_out;
    logic neg_out;

    assign is_lsl = (op == OP_SHIFT_LEFT_LOGICAL);
    assign is_lsr = (op == OP_SHIFT_RIGHT_LOGICAL);

    // Rotate pulls the old carry in at the bottom
    assign res = is_lsr ? {1'b0, val[DATA_W-1:1]}
               : is_lsl ? {val[DATA_W-2:0], 1'b0}
               : {val[DATA_W-2:0], flags_in[FLAG_C]};

    assign carry_out = is_lsr ? val[0] : val[DATA_W-1];
    assign neg_out   = res[DATA_W-1];

    // ************************************************************
    // Flags: only Z, C, N and V move
    // ************************************************************
    always_comb begin
        flags_res         = flags_in;
        flags_res[FLAG_Z] = (res == 8'h00);
        flags_res[FLAG_C] = carry_out;
        flags_res[FLAG_N] = neg_out;
        flags_res[FLAG_V] = neg_out ^ carry_out;
    end

endmodule

`default_nettype wire

// ---- bsbe_exec.sv ----
/*
 * Execution slice for conditional skips, conditional relative branches,
 * single I/O bit set/clear and one-bit shifts, plus a small control port.
 * Assumes the decode stage presents operands, current flags and the
 * address of the instruction together with the issue strobe.
 */
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ns
`default_nettype none

module bsbe_exec
    import bsbe_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic              issue,
    input  wire logic [4:0]        op,
    input  wire logic [2:0]        bit_sel,
    input  wire logic [2:0]        flag_sel,
    input  wire logic [OFS_W-1:0]  offset,
    input  wire logic [PC_W-1:0]   pc,
    input  wire logic              next_two_word,
    input  wire logic [DATA_W-1:0] reg_val,
    input  wire logic [IO_W-1:0]   io_addr_in,
    input  wire logic [DATA_W-1:0] io_val,
    input  wire logic [DATA_W-1:0] flags_in,
    input  wire logic [CSR_W-1:0]  csr_addr,
    input  wire logic [DATA_W-1:0] csr_wdata,
    input  wire logic              csr_wr,
    input  wire logic              csr_rd,
    output logic                   ready,
    output logic                   done,
    output logic                   pc_load,
    output logic      [PC_W-1:0]   pc_next,
    output logic                   rf_we,
    output logic      [DATA_W-1:0] rf_wdata,
    output logic                   flags_we,
    output logic      [DATA_W-1:0] flags_out,
    output logic                   io_we,
    output logic      [IO_W-1:0]   io_addr,
    output logic      [DATA_W-1:0] io_wdata,
    output logic      [DATA_W-1:0] csr_rdata
);

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // Branch table: {is branch, wanted level, flag index}
    function automatic logic [4:0] br_decode(input logic [4:0] o, input logic [2:0] s);
        case (o)
            OP_BRANCH_FLAG_SET:           br_decode = {2'b11, s};
            OP_BRANCH_FLAG_CLEAR:         br_decode = {2'b10, s};
            OP_BRANCH_EQUAL:              br_decode = {2'b11, FLAG_Z};
            OP_BRANCH_NOT_EQUAL:          br_decode = {2'b10, FLAG_Z};
            OP_BRANCH_CARRY_SET:          br_decode = {2'b11, FLAG_C};
            OP_BRANCH_LOWER:              br_decode = {2'b11, FLAG_C};
            OP_BRANCH_CARRY_CLEAR:        br_decode = {2'b10, FLAG_C};
            OP_BRANCH_SAME_OR_HIGHER:     br_decode = {2'b10, FLAG_C};
            OP_BRANCH_MINUS:              br_decode = {2'b11, FLAG_N};
            OP_BRANCH_PLUS:               br_decode = {2'b10, FLAG_N};
            OP_BRANCH_SIGNED_GE:          br_decode = {2'b10, FLAG_S};
            OP_BRANCH_SIGNED_LESS:        br_decode = {2'b11, FLAG_S};
            OP_BRANCH_HALF_CARRY_SET:     br_decode = {2'b11, FLAG_H};
            OP_BRANCH_HALF_CARRY_CLEAR:   br_decode = {2'b10, FLAG_H};
            OP_BRANCH_TRANSFER_BIT_SET:   br_decode = {2'b11, FLAG_T};
            OP_BRANCH_TRANSFER_BIT_CLEAR: br_decode = {2'b10, FLAG_T};
            OP_BRANCH_OVERFLOW_SET:       br_decode = {2'b11, FLAG_V};
            OP_BRANCH_OVERFLOW_CLEAR:     br_decode = {2'b10, FLAG_V};
            OP_BRANCH_IRQ_ENABLED:        br_decode = {2'b11, FLAG_I};
            OP_BRANCH_IRQ_DISABLED:       br_decode = {2'b10, FLAG_I};
            default:                      br_decode = 5'h00;
        endcase
    endfunction

    function automatic logic is_signed_br(input logic [4:0] o);
        is_signed_br = (o == OP_BRANCH_SIGNED_GE) || (o == OP_BRANCH_SIGNED_LESS);
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    bsbe_state_t       state_q;
    bsbe_state_t       state_d;
    logic [1:0]        cnt_q;
    logic [1:0]        cnt_d;
    logic              ready_q;
    logic              done_q;
    logic              pc_load_q;
    logic [PC_W-1:0]   pc_next_q;
    logic              rf_we_q;
    logic [DATA_W-1:0] rf_wdata_q;
    logic              flags_we_q;
    logic [DATA_W-1:0] flags_out_q;
    logic              io_we_q;
    logic [IO_W-1:0]   io_addr_q;
    logic [DATA_W-1:0] io_wdata_q;
    logic [DATA_W-1:0] csr_rdata_q;
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] count_q;
    logic              taken_q;
    logic              pend_taken_q;
    logic              pend_pc_q;
    logic              pend_rf_q;
    logic              pend_io_q;

    logic              accept;
    logic              fire;
    logic              is_skip_reg;
    logic              is_skip_io;
    logic              is_skip;
    logic              want_one;
    logic              test_bit;
    logic              skip_go;
    logic [4:0]        br_info;
    logic              is_branch;
    logic              flag_bit;
    logic              branch_go;
    logic              is_io_bit;
    logic              is_shift;
    logic              taken;
    logic [PC_W-1:0]   offset_ext;
    logic [PC_W-1:0]   pc_target;
    logic [DATA_W-1:0] bit_mask;
    logic [DATA_W-1:0] io_new;
    logic [DATA_W-1:0] sh_res;
    logic [DATA_W-1:0] sh_flags;
    logic [1:0]        cycles;
    logic              csr_ctrl_wr;
    logic [DATA_W-1:0] stat_word;
    logic [DATA_W-1:0] csr_mux;
    logic [DATA_W-1:0] count_d;

    // ************************************************************
    // Skip evaluation
    // ************************************************************
    assign is_skip_reg = (op == OP_SKIP_REG_BIT_CLEAR) || (op == OP_SKIP_REG_BIT_SET);
    assign is_skip_io  = (op == OP_SKIP_IO_BIT_CLEAR) || (op == OP_SKIP_IO_BIT_SET);
    assign is_skip     = is_skip_reg || is_skip_io;
    assign want_one    = (op == OP_SKIP_REG_BIT_SET) || (op == OP_SKIP_IO_BIT_SET);
    assign test_bit    = is_skip_reg ? reg_val[bit_sel] : io_val[bit_sel];
    // Clear variants skip on zero, set variants on one
    assign skip_go     = is_skip && (test_bit == want_one);

    // ************************************************************
    // Branch evaluation
    // ************************************************************
    assign br_info    = br_decode(op, flag_sel);
    assign is_branch  = br_info[4];
    // Signed tests use N xor V directly rather than a stored sign flag
    assign flag_bit   = is_signed_br(op) ? (flags_in[FLAG_N] ^ flags_in[FLAG_V])
                      : flags_in[br_info[2:0]];
    assign branch_go  = is_branch && (flag_bit == br_info[3]);
    assign offset_ext = {{(PC_W-OFS_W){offset[OFS_W-1]}}, offset};

    // ************************************************************
    // Target and cycle count
    // ************************************************************
    assign taken = skip_go || branch_go;

    always_comb begin
        pc_target = pc + PC_STEP_1;
        cycles    = CYC_1;
        if (skip_go) begin
            pc_target = pc + (next_two_word ? PC_STEP_3 : PC_STEP_2);
            cycles    = next_two_word ? CYC_3 : CYC_2;
        end else if (branch_go) begin
            pc_target = pc + offset_ext + PC_STEP_1;
            cycles    = CYC_2;
        end else if (is_io_bit) begin
            cycles    = CYC_2;
        end
    end

    // ************************************************************
    // I/O bit and shift data paths
    // ************************************************************
    assign is_io_bit = (op == OP_SET_IO_BIT) || (op == OP_CLEAR_IO_BIT);
    assign is_shift  = (op == OP_SHIFT_LEFT_LOGICAL) || (op == OP_SHIFT_RIGHT_LOGICAL)
                     || (op == OP_ROTATE_LEFT_CARRY);
    assign bit_mask  = 8'h01 << bit_sel;
    // Other bits are written back as read, so the register keeps them
    assign io_new    = (op == OP_SET_IO_BIT) ? (io_val | bit_mask)
                     : (io_val & ~bit_mask);

    bsbe_shift u_shift (
        .op        (op),
        .val       (reg_val),
        .flags_in  (flags_in),
        .res       (sh_res),
        .flags_res (sh_flags)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Issues are accepted only while ready; a held operation refuses new ones
    assign accept = issue && ready_q;
    assign fire   = (accept && (cycles == CYC_1))
                  || ((state_q == ST_HOLD) && (cnt_q == CYC_1));

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (accept && (cycles != CYC_1)) begin
                    state_d = ST_HOLD;
                    cnt_d   = cycles - CYC_1;
                end
            end
            ST_HOLD: begin
                cnt_d = cnt_q - CYC_1;
                if (cnt_q == CYC_1) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d   = 2'h0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            cnt_q   <= 2'h0;
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            ready_q <= ctrl_q[CTRL_EN] && (state_d == ST_IDLE);
        end
    end

    // ************************************************************
    // Pending results, latched at accept and held to completion
    // ************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pc_next_q    <= 16'h0000;
            rf_wdata_q   <= 8'h00;
            flags_out_q  <= 8'h00;
            io_addr_q    <= 6'h00;
            io_wdata_q   <= 8'h00;
            pend_taken_q <= 1'b0;
            pend_pc_q    <= 1'b0;
            pend_rf_q    <= 1'b0;
            pend_io_q    <= 1'b0;
        end else if (accept) begin
            pc_next_q    <= pc_target;
            rf_wdata_q   <= sh_res;
            // Skips and branches never touch the flags
            flags_out_q  <= sh_flags;
            io_addr_q    <= io_addr_in;
            io_wdata_q   <= io_new;
            pend_taken_q <= taken;
            pend_pc_q    <= is_skip || is_branch;
            pend_rf_q    <= is_shift;
            pend_io_q    <= is_io_bit;
        end
    end

    // ************************************************************
    // Completion strobes
    // ************************************************************
    // A one-cycle op must fire from the live decode, not the stale latch
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            done_q     <= 1'b0;
            pc_load_q  <= 1'b0;
            rf_we_q    <= 1'b0;
            flags_we_q <= 1'b0;
            io_we_q    <= 1'b0;
        end else begin
            done_q     <= fire;
            pc_load_q  <= fire && (accept ? (is_skip || is_branch) : pend_pc_q);
            rf_we_q    <= fire && (accept ? is_shift : pend_rf_q);
            flags_we_q <= fire && (accept ? is_shift : pend_rf_q);
            io_we_q    <= fire && (accept ? is_io_bit : pend_io_q);
        end
    end

    // ************************************************************
    // Control port
    // ************************************************************
    assign csr_ctrl_wr = csr_wr && (csr_addr == CSR_CTRL);
    assign stat_word   = {6'h00, taken_q, (state_q == ST_HOLD)};
    assign csr_mux     = (csr_addr == CSR_CTRL)  ? ctrl_q
                       : (csr_addr == CSR_STAT)  ? stat_word
                       : (csr_addr == CSR_COUNT) ? count_q
                       : 8'h00;
    // Clearing and counting in one cycle: the new event is kept
    assign count_d     = (csr_ctrl_wr && csr_wdata[CTRL_CLR]) ? 8'h00 : count_q;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q      <= CTRL_RST;
            count_q     <= 8'h00;
            taken_q     <= 1'b0;
            csr_rdata_q <= 8'h00;
        end else begin
            if (csr_ctrl_wr) begin
                ctrl_q <= {7'h00, csr_wdata[CTRL_EN]};
            end
            if (fire) begin
                taken_q <= accept ? taken : pend_taken_q;
            end
            // Counter saturates rather than wrap
            if (fire && (accept ? taken : pend_taken_q) && (count_d != 8'hff)) begin
                count_q <= count_d + 8'h01;
            end else begin
                count_q <= count_d;
            end
            csr_rdata_q <= csr_rd ? csr_mux : 8'h00;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign ready     = ready_q;
    assign done      = done_q;
    assign pc_load   = pc_load_q;
    assign pc_next   = pc_next_q;
    assign rf_we     = rf_we_q;
    assign rf_wdata  = rf_wdata_q;
    assign flags_we  = flags_we_q;
    assign flags_out = flags_out_q;
    assign io_we     = io_we_q;
    assign io_addr   = io_addr_q;
    assign io_wdata  = io_wdata_q;
    assign csr_rdata = csr_rdata_q;

endmodule

`default_nettype wire

// ---- bsbe_exec_assertions.sv ----
/* Port-level assertions for the execution slice.
   Assumes one clock domain and the async active-low reset. */
`timescale 1ns/1ns
`default_nettype none
module bsbe_exec_chk
    import bsbe_pkg::*;
(
    input wire logic        mclk,
    input wire logic        arst_n,
    input wire logic        issue,
    input wire logic [4:0]  op,
    input wire logic [2:0]  bit_sel,
    input wire logic [6:0]  offset,
    input wire logic [15:0] pc,
    input wire logic [7:0]  reg_val,
    input wire logic [7:0]  io_val,
    input wire logic [7:0]  flags_in,
    input wire logic        ready,
    input wire logic        done,
    input wire logic        pc_load,
    input wire logic [15:0] pc_next,
    input wire logic [7:0]  rf_wdata,
    input wire logic [7:0]  flags_out,
    input wire logic        io_we,
    input wire logic [7:0]  io_wdata
);
    logic acc;
    assign acc = issue && ready;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_shl;
        acc && op == OP_SHIFT_LEFT_LOGICAL |=> done && rf_wdata == {$past(reg_val[6:0]), 1'b0};
    endproperty
    a_shl: assert property (p_shl) else $error("shift left wrong");
    property p_shr;
        acc && op == OP_SHIFT_RIGHT_LOGICAL |=> rf_wdata == {1'b0, $past(reg_val[7:1])}
            && flags_out[0] == $past(reg_val[0]);
    endproperty
    a_shr: assert property (p_shr) else $error("shift right wrong");
    property p_rol;
        acc && op == OP_ROTATE_LEFT_CARRY |=> flags_out[0] == $past(reg_val[7])
            && rf_wdata == {$past(reg_val[6:0]), $past(flags_in[0])};
    endproperty
    a_rol: assert property (p_rol) else $error("rotate wrong");
    property p_sbi;
        acc && op == OP_SET_IO_BIT |=> io_wdata == ($past(io_val) | (8'h01 << $past(bit_sel)))
            ##1 done && io_we;
    endproperty
    a_sbi: assert property (p_sbi) else $error("set io bit wrong");
    property p_cbi;
        acc && op == OP_CLEAR_IO_BIT |=> io_wdata == ($past(io_val) & ~(8'h01 << $past(bit_sel)))
            ##1 done && io_we;
    endproperty
    a_cbi: assert property (p_cbi) else $error("clear io bit wrong");
    property p_beq;
        acc && op == OP_BRANCH_EQUAL && flags_in[1] |=> !done
            && pc_next == $past(pc) + {{9{$past(offset[6])}}, $past(offset)} + 16'h0001
            ##1 done && pc_load;
    endproperty
    a_beq: assert property (p_beq) else $error("equal branch wrong");
    property p_bne;
        acc && op == OP_BRANCH_NOT_EQUAL && flags_in[1] |=> done && pc_next == $past(pc) + 16'h0001;
    endproperty
    a_bne: assert property (p_bne) else $error("not-equal branch wrong");
    property p_skip_reg_bit_set;
        acc && op == OP_SKIP_REG_BIT_SET && reg_val[bit_sel] |=> !done
            && (pc_next == $past(pc) + 16'h0002 || pc_next == $past(pc) + 16'h0003);
    endproperty
    a_skip_reg_bit_set: assert property (p_skip_reg_bit_set) else $error("reg skip wrong");
    property p_skip_io_bit_clear;
        acc && op == OP_SKIP_IO_BIT_CLEAR && io_val[bit_sel] |=> done && pc_next == $past(pc) + 16'h0001;
    endproperty
    a_skip_io_bit_clear: assert property (p_skip_io_bit_clear) else $error("io skip wrong");
endmodule
bind bsbe_exec bsbe_exec_chk i_chk (.*);
`default_nettype wire

// ---- bsbe_exec_tb_top.sv ----
/* Self-checking bench for bsbe_exec.
   Drives issue and the control port directly; no far-side model. */
`timescale 1ns/1ns
`default_nettype none
module bsbe_exec_tb_top;
    import bsbe_pkg::*;
    logic mclk = 0, arst_n = 0, issue = 0, next_two_word = 0, csr_wr = 0, csr_rd = 0;
    logic [4:0] op = 0;
    logic [2:0] bit_sel = 0, flag_sel = 3'h3;
    logic [6:0] offset = 0;
    logic [15:0] pc = 0, pc_next;
    logic [7:0] reg_val = 0, io_val = 0, flags_in = 0, csr_wdata = 0, d;
    logic [7:0] rf_wdata, flags_out, io_wdata, csr_rdata;
    logic [5:0] io_addr_in = 6'h15, io_addr;
    logic [1:0] csr_addr = 0;
    logic ready, done, pc_load, rf_we, flags_we, io_we;
    int n_mismatch = 0, n_compared = 0, ncyc, cyc = 0;
    always #2 mclk = ~mclk;
    bsbe_exec i_dut (.*);
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (e !== g) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task run(input logic [4:0] o, input logic [2:0] b, input logic [6:0] k, input logic tw,
             input logic [7:0] rv, input logic [7:0] iv, input logic [7:0] fl);
        @(posedge mclk);
        {op, bit_sel, offset, next_two_word} <= {o, b, k, tw};
        {reg_val, io_val, flags_in, pc, issue} <= {rv, iv, fl, 16'h0100, 1'b1};
        ncyc = 0;
        do begin
            @(posedge mclk);
            issue <= 1'b0;
            #1 ncyc++;
        end while (done !== 1'b1 && ncyc < 5);
    endtask
    task csr(input logic w, input logic [1:0] a, input logic [7:0] wd);
        @(posedge mclk);
        {csr_addr, csr_wdata, csr_wr, csr_rd} <= {a, wd, w, !w};
        @(posedge mclk);
        {csr_wr, csr_rd} <= 2'b00;
        #1 d = csr_rdata;
    endtask
    function automatic logic take(int o, logic [7:0] f, int s);
        logic c;
        case (o)
            5, 6: c = f[s];
            21, 22: c = f[3];
            7, 8: c = f[1];
            9, 10, 11, 12: c = f[0];
            13, 14: c = f[2];
            15, 16: c = f[2] ^ f[3];
            17, 18: c = f[5];
            19, 20: c = f[6];
            default: c = f[7];
        endcase
        return c == (o inside {5, 7, 9, 12, 13, 16, 17, 19, 21, 23});
    endfunction
    task t_csr;
        csr(0, 2'h0, 0);
        chk("ctrl reset", 8'h01, d);
        csr(0, 2'h3, 0);
        chk("unmapped read", 0, d);
        csr(1, 2'h0, 8'h00);
        run(OP_SHIFT_LEFT_LOGICAL, 0, 0, 0, 8'h01, 0, 0);
        chk("refused issue", 5, ncyc);
        chk("ready off", 0, ready);
        csr(1, 2'h0, 8'h01);
        run(OP_BRANCH_EQUAL, 0, 7'h05, 0, 0, 0, 8'h02);
        chk("taken branch", 16'h0106, pc_next);
        csr(0, 2'h1, 0);
        chk("status", 8'h02, d);
        csr(0, 2'h2, 0);
        chk("count", 8'h01, d);
        csr(1, 2'h0, 8'h03);
        csr(0, 2'h2, 0);
        chk("count cleared", 8'h00, d);
        csr(0, 2'h0, 0);
        chk("ctrl after clear", 8'h01, d);
        $display("control test done");
    endtask
    task t_branch;
        logic [7:0] fl [3] = '{8'h00, 8'hff, 8'h04};
        logic [6:0] k;
        logic t;
        for (int o = 5; o <= 24; o++) for (int i = 0; i < 3; i++) begin
            k = (i == 1) ? 7'h3f : 7'h7c;
            t = take(o, fl[i], (i == 2) ? 2 : i * 7);
            @(posedge mclk) flag_sel <= (i == 2) ? 3'h2 : 3'(i * 7);
            run(o[4:0], 0, k, 0, 0, 0, fl[i]);
            chk("branch pc", t ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101, pc_next);
            chk("branch cycles", t ? 2 : 1, ncyc);
            chk("branch load", 2'b10, {pc_load, flags_we});
        end
        $display("branch test done");
    endtask
    task t_skip;
        logic [7:0] p;
        int n;
        for (int o = 1; o <= 4; o++) for (int v = 0; v < 4; v++) begin
            p = v[0] ? 8'h20 : 8'hdf;
            n = (v[0] ^ o[0]) ? (v[1] ? 3 : 2) : 1;
            run(o[4:0], 3'h5, 0, v[1], o < 3 ? p : ~p, o < 3 ? ~p : p, 0);
            chk("skip pc", 16'h0100 + n, pc_next);
            chk("skip cycles", n, ncyc);
            chk("skip load", 2'b10, {pc_load, flags_we});
        end
        $display("skip test done");
    endtask
    task t_io_shift;
        logic [7:0] er [2][3] = '{'{8'h02, 8'h40, 8'h03}, '{8'h00, 8'h40, 8'h00}};
        logic [7:0] r;
        logic c;
        for (int o = 25; o <= 26; o++) begin
            run(o[4:0], o == 25 ? 3'h1 : 3'h0, 0, 0, 0, 8'ha5, 0);
            chk("io data", o == 25 ? 8'ha7 : 8'ha4, io_wdata);
            chk("io strobe", {2'h2, 1'b1, 6'h15}, {ncyc[1:0], io_we, io_addr});
        end
        for (int v = 0; v < 2; v++) for (int o = 27; o <= 29; o++) begin
            run(o[4:0], 0, 0, 0, v ? 8'h80 : 8'h81, 0, v ? 8'h00 : 8'h01);
            r = er[v][o-27];
            c = !(v == 1 && o == 28);
            chk("shift result", r, rf_wdata);
            chk("shift flags", {4'h0, r[7] ^ c, r[7], r == 0, c}, flags_out);
            chk("shift strobe", 4'b0111, {ncyc[1:0], rf_we, flags_we});
        end
        $display("io and shift test done");
    endtask
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        t_csr;
        t_branch;
        t_skip;
        t_io_shift;
        tally_and_finish;
    end
endmodule
`default_nettype wire
